//--- host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic clk,
   input  wire logic miso,
   input  wire logic miso_oe,
   output logic      sclk = 1'b0,
   output logic      cs_n = 1'b1,
   output logic      mosi = 1'b0
);
   logic tog = 1'b0;
   wire logic line = miso_oe ? miso : tog;
   always @(negedge clk) tog <= ~tog;
   // Mode 0 frame, half period of 8 clocks; host supplies levels in meter units
   task automatic xfer(input logic [47:0] frame, output logic [31:0] rdata);
      cs_n <= 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 47; i >= 0; i--) begin
         mosi <= frame[i];
         repeat (8) @(negedge clk);
         sclk <= 1'b1;
         if (i < 32) rdata[i] = line;
         repeat (8) @(negedge clk);
         sclk <= 1'b0;
      end
      mosi <= ~mosi;
      cs_n <= 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- rms_limit_check.sv
// Functional notes
// - Levels compare against bits 23 to 8 of each RMS result.
// - RMS above its high level sets the high-voltage or high-current flag.
// - A set flag drives the interrupt output only when its enable is set.
// - Flags are sticky; hardware never clears them, only a host write of ones or reset does.
// - Frame period is divider plus one times eight clock periods.
// - Default divider gives a 360 microsecond frame at this clock.
// - All thresholds and comparisons are in fixed-point meter units.
// - Current RMS results carry full-scale current over two to the 24.
// - Voltage RMS results carry full-scale voltage over two to the 24.
// - Energy LSB is full-scale voltage times current times frame over 2^16.
// - Power LSB is full-scale voltage times current over two to the 32.
// - Amp-hour LSB is full-scale current times frame period over 2^16.
// - Current levels carry full-scale current over two to the 16.
// - Virtual reads return results times the programmed conversion coefficient, shifted right by 4 bits.
// - Address 0x1CC reads phase A current RMS in meter units.
// - Address 0x831 reads phase A current RMS times current coefficient, over 16.
// - Any phase voltage RMS above the high level sets the high-voltage flag.
// - A newly set global flag with its mask bit set raises the interrupt.
// - Each phase keeps local copies of its own condition flags.
`timescale 1ns/100ps
`default_nettype none
module rms_limit_check #(
   parameter logic [rms_limit_pkg::DIV_W-1:0] FRAME_DIV_RESET = rms_limit_pkg::ADC_DIV_RESET
) (
   input  wire logic                                                  REF_CLK,
   input  wire logic                                                  ARST_N,
   input  wire logic                                                  SCLK,
   input  wire logic                                                  CS_N,
   input  wire logic                                                  MOSI,
   output logic                                                       MISO,
   output logic                                                       MISO_OE,
   output logic                                                       IRQ,
   output logic                                                       FRAME_TICK,
   input  wire logic                                                  RMS_VALID,
   input  wire logic [rms_limit_pkg::PHASES-1:0][rms_limit_pkg::DATA_W-1:0] CURRENT_RMS,
   input  wire logic [rms_limit_pkg::PHASES-1:0][rms_limit_pkg::DATA_W-1:0] VOLTAGE_RMS,
   input  wire logic [rms_limit_pkg::PHASES-1:0]                      ZERO_CROSS_MISSING,
   input  wire logic [rms_limit_pkg::PHASES-1:0]                      DIR_CHANGE
);
   import rms_limit_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [LEVEL_W-1:0]             hv_level;
      logic [LEVEL_W-1:0]             hc_level;
      logic [LEVEL_W-1:0]             lv_level;
      logic [DIV_W-1:0]               frame_div;
      logic [COEFF_W-1:0]             cur_coeff;
      logic [COEFF_W-1:0]             volt_coeff;
      logic [DATA_W-1:0]              cur_rms_a;
      logic [DATA_W-1:0]              volt_rms_a;
      logic [FLAG_W-1:0]              irq_flag;
      logic [FLAG_W-1:0]              irq_mask;
      logic [PHASES-1:0][FLAG_W-1:0]  phase_flag;
      logic [FRAME_CNT_W-1:0]         frame_cnt;
      logic                           frame_tick;
   } state_type;

   localparam state_type STATE_RESET = '{hv_level: HIGH_LEVEL_RESET, hc_level: HIGH_LEVEL_RESET,
                                         lv_level: LOW_LEVEL_RESET, frame_div: FRAME_DIV_RESET,
                                         cur_coeff: COEFF_RESET, volt_coeff: COEFF_RESET,
                                         cur_rms_a: '0, volt_rms_a: '0, irq_flag: '0,
                                         irq_mask: MASK_RESET, phase_flag: '0,
                                         frame_cnt: '0, frame_tick: 1'b0};

   state_type                     s_q;
   state_type                     s_d;
   logic [ADDR_W-1:0]             cmd_addr;
   logic                          rd_load;
   logic [DATA_W-1:0]             rd_data;
   logic                          wr_valid;
   logic [DATA_W-1:0]             wr_data;
   logic [DATA_W-1:0]             scale_val;
   logic [COEFF_W-1:0]            scale_coeff;
   logic [DATA_W-1:0]             scaled;
   logic [PHASES-1:0][FLAG_W-1:0] phase_set;
   logic [PHASES-1:0][FLAG_W-1:0] phase_clr;
   logic [FLAG_W-1:0]             irq_set;
   logic [FLAG_W-1:0]             irq_clr;
   logic [FRAME_CNT_W-1:0]        frame_top;

   // ----------------------------------------------------------------
   // Serial register port
   // ----------------------------------------------------------------
   serial_reg_port u_port (
      .clk      (REF_CLK),
      .arst_n   (ARST_N),
      .sclk     (SCLK),
      .cs_n     (CS_N),
      .mosi     (MOSI),
      .miso     (MISO),
      .miso_oe  (MISO_OE),
      .cmd_addr (cmd_addr),
      .rd_load  (rd_load),
      .rd_data  (rd_data),
      .wr_valid (wr_valid),
      .wr_data  (wr_data)
   );

   // ----------------------------------------------------------------
   // Virtual register scaling
   // ----------------------------------------------------------------
   assign scale_val   = (cmd_addr == ADDR_VOLT_SCALED_A) ? s_q.volt_rms_a : s_q.cur_rms_a;
   assign scale_coeff = (cmd_addr == ADDR_VOLT_SCALED_A) ? s_q.volt_coeff : s_q.cur_coeff;

   unit_scaler u_scaler (
      .result (scale_val),
      .coeff  (scale_coeff),
      .scaled (scaled)
   );

   // ----------------------------------------------------------------
   // Per-phase limit compare and flag clears
   // ----------------------------------------------------------------
   for (genvar p = 0; p < PHASES; p++) begin : g_phase
      assign phase_set[p][FLAG_HC]   = RMS_VALID && (CURRENT_RMS[p][LEVEL_MSB:LEVEL_LSB] > s_q.hc_level);
      assign phase_set[p][FLAG_HV]   = RMS_VALID && (VOLTAGE_RMS[p][LEVEL_MSB:LEVEL_LSB] > s_q.hv_level);
      assign phase_set[p][FLAG_LV]   = RMS_VALID && !(VOLTAGE_RMS[p][LEVEL_MSB:LEVEL_LSB] > s_q.lv_level);
      assign phase_set[p][FLAG_NOZC] = ZERO_CROSS_MISSING[p];
      assign phase_set[p][FLAG_DIR]  = DIR_CHANGE[p];
      assign phase_clr[p] = (wr_valid && cmd_addr == ADDR_PHASE_FLAG_A + ADDR_W'(p)) ?
                            wr_data[FLAG_W-1:0] : '0;
   end

   assign irq_set   = phase_set[0] | phase_set[1] | phase_set[2];
   assign irq_clr   = (wr_valid && cmd_addr == ADDR_IRQ_FLAG) ? wr_data[FLAG_W-1:0] : '0;
   assign frame_top = {1'b0, s_q.frame_div, 3'b111};

   // ----------------------------------------------------------------
   // Next state and read data
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.frame_tick = 1'b0;
      if (s_q.frame_cnt >= frame_top) begin
         s_d.frame_cnt  = '0;
         s_d.frame_tick = 1'b1;
      end else begin
         s_d.frame_cnt = s_q.frame_cnt + 20'h00001;
      end
      if (RMS_VALID) begin
         s_d.cur_rms_a  = CURRENT_RMS[0];
         s_d.volt_rms_a = VOLTAGE_RMS[0];
      end
      s_d.irq_flag = (s_q.irq_flag & ~irq_clr) | irq_set;
      for (int p = 0; p < PHASES; p++) begin
         s_d.phase_flag[p] = (s_q.phase_flag[p] & ~phase_clr[p]) | phase_set[p];
      end
      if (wr_valid) begin
         case (cmd_addr)
            ADDR_HV_LEVEL:   s_d.hv_level   = wr_data[LEVEL_W-1:0];
            ADDR_HC_LEVEL:   s_d.hc_level   = wr_data[LEVEL_W-1:0];
            ADDR_LV_LEVEL:   s_d.lv_level   = wr_data[LEVEL_W-1:0];
            ADDR_FRAME_DIV:  s_d.frame_div  = wr_data[DIV_W-1:0];
            ADDR_CUR_COEFF:  s_d.cur_coeff  = wr_data[COEFF_W-1:0];
            ADDR_VOLT_COEFF: s_d.volt_coeff = wr_data[COEFF_W-1:0];
            ADDR_IRQ_MASK:   s_d.irq_mask   = wr_data[FLAG_W-1:0];
            default: begin
            end
         endcase
      end
      rd_data = '0;
      case (cmd_addr)
         ADDR_CUR_RMS_A:     rd_data = s_q.cur_rms_a;
         ADDR_VOLT_RMS_A:    rd_data = s_q.volt_rms_a;
         ADDR_CUR_SCALED_A:  rd_data = scaled;
         ADDR_VOLT_SCALED_A: rd_data = scaled;
         ADDR_HV_LEVEL:      rd_data = {16'h0000, s_q.hv_level};
         ADDR_HC_LEVEL:      rd_data = {16'h0000, s_q.hc_level};
         ADDR_LV_LEVEL:      rd_data = {16'h0000, s_q.lv_level};
         ADDR_FRAME_DIV:     rd_data = {16'h0000, s_q.frame_div};
         ADDR_CUR_COEFF:     rd_data = {16'h0000, s_q.cur_coeff};
         ADDR_VOLT_COEFF:    rd_data = {16'h0000, s_q.volt_coeff};
         ADDR_IRQ_FLAG:      rd_data = {27'h0000000, s_q.irq_flag};
         ADDR_IRQ_MASK:      rd_data = {27'h0000000, s_q.irq_mask};
         default: begin
            for (int p = 0; p < PHASES; p++) begin
               if (cmd_addr == ADDR_PHASE_FLAG_A + ADDR_W'(p)) begin
                  rd_data = {27'h0000000, s_q.phase_flag[p]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign IRQ        = |(s_q.irq_flag & s_q.irq_mask);
   assign FRAME_TICK = s_q.frame_tick;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [FRAME_CNT_W-1:0] gap_cnt;
   logic                   gap_ok;
   logic                   div_write;
   logic                   mask_write;

   assign div_write  = wr_valid && cmd_addr == ADDR_FRAME_DIV;
   assign mask_write = wr_valid && cmd_addr == ADDR_IRQ_MASK;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gap_cnt <= '0;
         gap_ok  <= 1'b0;
      end else if (s_q.frame_tick) begin
         gap_cnt <= 20'h00001;
         gap_ok  <= !div_write;
      end else begin
         gap_cnt <= gap_cnt + 20'h00001;
         if (div_write) begin
            gap_ok <= 1'b0;
         end
      end
   end

   chk_hc_flag_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      RMS_VALID && (CURRENT_RMS[0][23:8] > s_q.hc_level) |=> s_q.irq_flag[FLAG_HC] && s_q.phase_flag[0][FLAG_HC])
      else $error("high current not flagged");

   chk_hc_no_false: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      RMS_VALID && (CURRENT_RMS[0][23:8] <= s_q.hc_level) && !s_q.phase_flag[0][FLAG_HC] |=>
      !s_q.phase_flag[0][FLAG_HC])
      else $error("high current flagged at or below level");

   chk_hv_any_phase: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      RMS_VALID && (VOLTAGE_RMS[2][23:8] > s_q.hv_level) |=> s_q.irq_flag[FLAG_HV] && s_q.phase_flag[2][FLAG_HV])
      else $error("high voltage on phase C not flagged");

   chk_irq_gated: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      s_q.irq_mask == 5'h00 && !mask_write |=> !IRQ)
      else $error("interrupt raised with all enables off");

   chk_irq_raise: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      irq_set[FLAG_HC] && s_q.irq_mask[FLAG_HC] && !mask_write |=> IRQ)
      else $error("enabled flag did not raise interrupt");

   chk_flag_sticky: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      1'b1 |=> ((($past(s_q.irq_flag) & ~$past(irq_clr)) & ~s_q.irq_flag) == 5'h00))
      else $error("flag cleared without host write");

   chk_set_wins: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (irq_set & irq_clr) != 5'h00 |=> (s_q.irq_flag & $past(irq_set)) == $past(irq_set))
      else $error("clear overrode a simultaneous set");

   chk_frame_period: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      s_q.frame_tick && gap_ok |-> gap_cnt == ({4'h0, s_q.frame_div} + 20'h00001) * 20'h00008)
      else $error("frame period differs from divider setting");

   chk_frame_default: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      s_q.frame_tick && gap_ok && s_q.frame_div == ADC_DIV_RESET |-> gap_cnt == 20'(FRAME_DEFAULT_CYCLES))
      else $error("default frame is not 360 us");

   chk_raw_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      rd_load && cmd_addr == ADDR_CUR_RMS_A |-> rd_data == s_q.cur_rms_a)
      else $error("raw current read wrong");

   chk_scaled_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      rd_load && cmd_addr == ADDR_CUR_SCALED_A |->
      rd_data == 32'((48'(s_q.cur_rms_a) * 48'(s_q.cur_coeff)) >> 4))
      else $error("scaled current read wrong");

   chk_virtual_nowrite: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      wr_valid && cmd_addr == ADDR_CUR_SCALED_A |=> $stable(s_q.cur_coeff) && $stable(s_q.cur_rms_a)
      && $stable(s_q.hc_level))
      else $error("write to virtual register changed state");

endmodule
`default_nettype wire

//--- rms_limit_check_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rms_limit_check_tb;
   import rms_limit_pkg::*;
   typedef struct packed {
      logic [15:0] hv;
      logic [15:0] hc;
      logic [31:0] cur;
      logic [31:0] volt;
      logic [4:0]  flags;
   } row_type;
   row_type rows [4] = '{'{16'h1234, 16'h1234, 32'h00123400, 32'h00123400, 5'h00},
                         '{16'h1234, 16'h1234, 32'h00123500, 32'h001234FF, 5'h01},
                         '{16'h1234, 16'h1234, 32'hFF1234FF, 32'h00123500, 5'h02},
                         '{16'hFFFF, 16'h0000, 32'h00000100, 32'h000000FF, 5'h05}};
   logic                          REF_CLK = 1'b0;
   logic                          ARST_N = 1'b0;
   logic                          RMS_VALID = 1'b0;
   logic [PHASES-1:0][DATA_W-1:0] CURRENT_RMS = '0;
   logic [PHASES-1:0][DATA_W-1:0] VOLTAGE_RMS = '0;
   logic [PHASES-1:0]             ZERO_CROSS_MISSING = '0;
   logic [PHASES-1:0]             DIR_CHANGE = '0;
   logic                          SCLK, CS_N, MOSI, MISO, MISO_OE, IRQ, FRAME_TICK;
   logic [31:0]                   r;
   int                            num_errors = 0;
   int                            num_checks = 0;
   int                            cycles = 0;
   int                            n;
   always #4 REF_CLK = ~REF_CLK;
   rms_limit_check #(.FRAME_DIV_RESET(16'h0003)) rms_limit_check_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SCLK(SCLK),
      .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE), .IRQ(IRQ), .FRAME_TICK(FRAME_TICK),
      .RMS_VALID(RMS_VALID), .CURRENT_RMS(CURRENT_RMS), .VOLTAGE_RMS(VOLTAGE_RMS),
      .ZERO_CROSS_MISSING(ZERO_CROSS_MISSING), .DIR_CHANGE(DIR_CHANGE));
   host_model host_model_i (.clk(REF_CLK), .miso(MISO), .miso_oe(MISO_OE), .sclk(SCLK), .cs_n(CS_N), .mosi(MOSI));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      host_model_i.xfer({4'h8, a, d}, x);
   endtask
   task automatic rd(input logic [11:0] a);
      host_model_i.xfer({4'h0, a, 32'h0}, r);
   endtask
   task automatic rms(input logic [31:0] c, input logic [31:0] v);
      CURRENT_RMS <= {3{c}};
      VOLTAGE_RMS <= {3{v}};
      RMS_VALID <= 1'b1;
      @(negedge REF_CLK);
      RMS_VALID <= 1'b0;
      @(negedge REF_CLK);
   endtask
   task automatic results;
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (12) @(negedge REF_CLK);
      chk("irq in reset", 32'h0, {31'h0, IRQ});
      chk("miso_oe in reset", 32'h0, {31'h0, MISO_OE});
      ARST_N <= 1'b1;
      n = 0;
      while (FRAME_TICK !== 1'b1 && n < 100) begin
         @(negedge REF_CLK);
         n++;
      end
      n = 0;
      do begin
         @(negedge REF_CLK);
         n++;
      end while (FRAME_TICK !== 1'b1 && n < 100);
      chk("frame period", 32'd32, n);
      chk("default frame", 32'h0000AFC8, (32'(ADC_DIV_RESET) + 32'h1) * 32'h8);
      rd(ADDR_HC_LEVEL);
      chk("hc level reset", 32'h0000FFFF, r);
      foreach (rows[i]) begin
         wr(ADDR_HV_LEVEL, {16'h0, rows[i].hv});
         wr(ADDR_HC_LEVEL, {16'h0, rows[i].hc});
         rms(rows[i].cur, rows[i].volt);
         rd(ADDR_IRQ_FLAG);
         chk("global flags", {27'h0, rows[i].flags}, r);
         rd(ADDR_PHASE_FLAG_A);
         chk("phase a flags", {27'h0, rows[i].flags}, r);
         rd(ADDR_CUR_RMS_A);
         chk("current rms", rows[i].cur, r);
         wr(ADDR_IRQ_FLAG, 32'h1F);
         wr(ADDR_PHASE_FLAG_A, 32'h1F);
      end
      rms(32'h00123500, 32'h00123400);
      chk("irq masked", 32'h0, {31'h0, IRQ});
      rms(32'h00000000, 32'h00123400);
      rd(ADDR_IRQ_FLAG);
      chk("sticky flag", 32'h01, r);
      wr(ADDR_IRQ_MASK, 32'h01);
      chk("irq enabled", 32'h1, {31'h0, IRQ});
      wr(ADDR_IRQ_FLAG, 32'h01);
      chk("irq cleared", 32'h0, {31'h0, IRQ});
      wr(ADDR_CUR_COEFF, 32'h0190);
      rms(32'h07654AF0, 32'h00123400);
      wr(ADDR_CUR_SCALED_A, 32'h0);
      rd(ADDR_CUR_SCALED_A);
      chk("scaled current", 32'hB8E45170, r);
      wr(ADDR_CUR_COEFF, 32'h0001);
      rd(ADDR_CUR_SCALED_A);
      chk("rescaled current", 32'h007654AF, r);
      ZERO_CROSS_MISSING <= 3'b010;
      DIR_CHANGE         <= 3'b100;
      @(negedge REF_CLK);
      ZERO_CROSS_MISSING <= 3'b000;
      DIR_CHANGE         <= 3'b000;
      rd(ADDR_PHASE_FLAG_A + 12'h001);
      chk("phase b flags", 32'h0000000F, r);
      rd(ADDR_PHASE_FLAG_A + 12'h002);
      chk("phase c flags", 32'h00000017, r);
      chk("irq before reset", 32'h1, {31'h0, IRQ});
      ARST_N <= 1'b0;
      @(negedge REF_CLK);
      chk("irq after reset", 32'h0, {31'h0, IRQ});
      ARST_N <= 1'b1;
      repeat (5) @(negedge REF_CLK);
      rd(ADDR_IRQ_FLAG);
      chk("flags after reset", 32'h0, r);
      results();
   end
endmodule
`default_nettype wire

//--- rms_limit_pkg.sv
`default_nettype none
package rms_limit_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 12;
   localparam int DATA_W      = 32;
   localparam int LEVEL_W     = 16;
   localparam int COEFF_W     = 16;
   localparam int DIV_W       = 16;
   localparam int FRAME_CNT_W = 20;
   localparam int PROD_W      = DATA_W + COEFF_W;
   localparam int PHASES      = 3;
   localparam int FLAG_W      = 5;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CUR_RMS_A     = 12'h1CC;
   localparam logic [ADDR_W-1:0] ADDR_VOLT_RMS_A    = 12'h1C8;
   localparam logic [ADDR_W-1:0] ADDR_CUR_SCALED_A  = 12'h831;
   localparam logic [ADDR_W-1:0] ADDR_VOLT_SCALED_A = 12'h830;
   localparam logic [ADDR_W-1:0] ADDR_HV_LEVEL      = 12'h040;
   localparam logic [ADDR_W-1:0] ADDR_HC_LEVEL      = 12'h041;
   localparam logic [ADDR_W-1:0] ADDR_LV_LEVEL      = 12'h042;
   localparam logic [ADDR_W-1:0] ADDR_FRAME_DIV     = 12'h043;
   localparam logic [ADDR_W-1:0] ADDR_CUR_COEFF     = 12'h044;
   localparam logic [ADDR_W-1:0] ADDR_VOLT_COEFF    = 12'h045;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAG      = 12'h048;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK      = 12'h049;
   localparam logic [ADDR_W-1:0] ADDR_PHASE_FLAG_A  = 12'h04A;

   // ----------------------------------------------------------------
   // Flag bit positions
   // ----------------------------------------------------------------
   localparam int FLAG_HC   = 0;
   localparam int FLAG_HV   = 1;
   localparam int FLAG_LV   = 2;
   localparam int FLAG_NOZC = 3;
   localparam int FLAG_DIR  = 4;

   // ----------------------------------------------------------------
   // Meter unit fractions and level alignment
   // ----------------------------------------------------------------
   localparam int RMS_FRAC_BITS     = 24;
   localparam int ENERGY_FRAC_BITS  = 16;
   localparam int POWER_FRAC_BITS   = 32;
   localparam int AMPHOUR_FRAC_BITS = 16;
   localparam int LEVEL_FRAC_BITS   = 16;
   localparam int LEVEL_MSB         = 23;
   localparam int LEVEL_LSB         = LEVEL_MSB - LEVEL_FRAC_BITS + 1;
   localparam int SCALE_SHIFT       = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [LEVEL_W-1:0] HIGH_LEVEL_RESET = 16'hFFFF;
   localparam logic [LEVEL_W-1:0] LOW_LEVEL_RESET  = 16'h0000;
   localparam logic [COEFF_W-1:0] COEFF_RESET      = 16'h0001;
   localparam logic [FLAG_W-1:0]  MASK_RESET       = 5'h00;

   // ----------------------------------------------------------------
   // Frame timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS        = 8000;
   localparam int FRAME_TIME_US        = 360;
   localparam int FRAME_CLKS_PER_STEP  = 8;
   localparam int FRAME_DEFAULT_CYCLES = (FRAME_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam logic [DIV_W-1:0] ADC_DIV_RESET =
      DIV_W'(FRAME_DEFAULT_CYCLES / FRAME_CLKS_PER_STEP - 1);

   // ----------------------------------------------------------------
   // Serial frame layout
   // ----------------------------------------------------------------
   localparam int CMD_BITS  = 16;
   localparam int XFER_BITS = CMD_BITS + DATA_W;
   localparam int WRITE_BIT = 15;
   localparam int CNT_W     = 6;

endpackage
`default_nettype wire

//--- serial_reg_port.sv
`timescale 1ns/100ps
`default_nettype none
module serial_reg_port (
   input  wire logic                              clk,
   input  wire logic                              arst_n,
   input  wire logic                              sclk,
   input  wire logic                              cs_n,
   input  wire logic                              mosi,
   output logic                                   miso,
   output logic                                   miso_oe,
   output logic [rms_limit_pkg::ADDR_W-1:0]       cmd_addr,
   output logic                                   rd_load,
   input  wire logic [rms_limit_pkg::DATA_W-1:0]  rd_data,
   output logic                                   wr_valid,
   output logic [rms_limit_pkg::DATA_W-1:0]       wr_data
);
   import rms_limit_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]        sclk_sync;
      logic [2:0]        cs_sync;
      logic [2:0]        mosi_sync;
      logic              sclk_f;
      logic              cs_f;
      logic              mosi_f;
      logic [CNT_W-1:0]  bit_cnt;
      logic [DATA_W-1:0] in_sh;
      logic [DATA_W-1:0] out_sh;
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic              cmd_done;
      logic              wr_done;
   } link_type;

   localparam link_type LINK_RESET = '{sclk_sync: 3'h0, cs_sync: 3'h7, mosi_sync: 3'h0,
                                       sclk_f: 1'b0, cs_f: 1'b1, mosi_f: 1'b0,
                                       bit_cnt: '0, in_sh: '0, out_sh: '0, addr: '0,
                                       write: 1'b0, cmd_done: 1'b0, wr_done: 1'b0};

   link_type s_q;
   link_type s_d;

   // ----------------------------------------------------------------
   // Sampling, shifting and command decode
   // ----------------------------------------------------------------
   always_comb begin
      logic sclk_new;
      logic cs_new;
      logic mosi_new;
      sclk_new = s_q.sclk_f;
      cs_new   = s_q.cs_f;
      mosi_new = s_q.mosi_f;
      s_d = s_q;
      s_d.sclk_sync = {s_q.sclk_sync[1:0], sclk};
      s_d.cs_sync   = {s_q.cs_sync[1:0], cs_n};
      s_d.mosi_sync = {s_q.mosi_sync[1:0], mosi};
      if (s_q.sclk_sync[1] == s_q.sclk_sync[2]) begin
         sclk_new = s_q.sclk_sync[1];
      end
      if (s_q.cs_sync[1] == s_q.cs_sync[2]) begin
         cs_new = s_q.cs_sync[1];
      end
      if (s_q.mosi_sync[1] == s_q.mosi_sync[2]) begin
         mosi_new = s_q.mosi_sync[1];
      end
      s_d.sclk_f   = sclk_new;
      s_d.cs_f     = cs_new;
      s_d.mosi_f   = mosi_new;
      s_d.cmd_done = 1'b0;
      s_d.wr_done  = 1'b0;
      if (cs_new) begin
         s_d.bit_cnt = '0;
      end else if (sclk_new && !s_q.sclk_f && s_q.bit_cnt < CNT_W'(XFER_BITS)) begin
         s_d.in_sh   = {s_q.in_sh[DATA_W-2:0], mosi_new};
         s_d.bit_cnt = s_q.bit_cnt + 6'h01;
         if (s_q.bit_cnt == CNT_W'(CMD_BITS - 1)) begin
            s_d.addr     = {s_q.in_sh[ADDR_W-2:0], mosi_new};
            s_d.write    = s_q.in_sh[WRITE_BIT-1];
            s_d.cmd_done = 1'b1;
         end
         if (s_q.bit_cnt == CNT_W'(XFER_BITS - 1)) begin
            s_d.wr_done = s_q.write;
         end
      end else if (!sclk_new && s_q.sclk_f && s_q.bit_cnt > CNT_W'(CMD_BITS)) begin
         s_d.out_sh = {s_q.out_sh[DATA_W-2:0], 1'b0};
      end
      if (s_q.cmd_done) begin
         s_d.out_sh = rd_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= LINK_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign miso     = s_q.out_sh[DATA_W-1];
   assign miso_oe  = !s_q.cs_f;
   assign cmd_addr = s_q.addr;
   assign rd_load  = s_q.cmd_done;
   assign wr_valid = s_q.wr_done;
   assign wr_data  = s_q.in_sh;

endmodule
`default_nettype wire

//--- unit_scaler.sv
`timescale 1ns/100ps
`default_nettype none
module unit_scaler (
   input  wire logic [rms_limit_pkg::DATA_W-1:0]  result,
   input  wire logic [rms_limit_pkg::COEFF_W-1:0] coeff,
   output logic      [rms_limit_pkg::DATA_W-1:0]  scaled
);
   import rms_limit_pkg::*;

   // ----------------------------------------------------------------
   // Product of result and coefficient
   // ----------------------------------------------------------------
   logic [PROD_W-1:0] product;

   assign product = PROD_W'(result) * PROD_W'(coeff);
   assign scaled  = product[DATA_W+SCALE_SHIFT-1:SCALE_SHIFT];

endmodule
`default_nettype wire
